//--- rtl/egp_cfg.svh
`ifndef EGP_CFG_SVH
`define EGP_CFG_SVH
// Register byte offsets on the Wishbone bus
`define EGP_OFS_P0_DATA   8'h00
`define EGP_OFS_P0_DIR    8'h04
`define EGP_OFS_P0_PULL   8'h08
`define EGP_OFS_AIN_DIS   8'h0c
`define EGP_OFS_P1_DATA   8'h10
`define EGP_OFS_P1_DIR    8'h14
`define EGP_OFS_P1_PULL   8'h18
`define EGP_OFS_STBY      8'h1c
`define EGP_OFS_CMP       8'h20
// Field positions
`define EGP_STBY_ISO_BIT  0
`define EGP_STBY_MODE_BIT 1
`define EGP_CMP_DIS_BIT   0
`define EGP_P1_NOPULL_BIT 2
`define EGP_P1_SCK_BIT    4
`define EGP_P1_SRX_BIT    6
// Reset values
`define EGP_RST_BYTE      8'h00
`define EGP_RST_CMP       1'b1
`endif

//--- rtl/egp_pkg.sv
package egp_pkg;
  // Bus slave phase
  typedef enum logic [0:0] {
    EGP_IDLE = 1'b0,
    EGP_ACK  = 1'b1
  } egp_phase_e;

  // One port's pad drive
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull;
  } egp_pad_s;

  // Whole block state
  typedef struct packed {
    egp_phase_e phase;
    logic [31:0] rdat;
    logic [7:0]  p0_data;
    logic [7:0]  p0_dir;
    logic [7:0]  p0_pull;
    logic [7:0]  ain_dis;
    logic [7:0]  p1_data;
    logic [7:0]  p1_dir;
    logic [7:0]  p1_pull;
    logic [1:0]  stby;
    logic        cmp_dis;
    logic [7:0]  p0_s1;
    logic [7:0]  p0_s2;
    logic [7:0]  p1_s1;
    logic [7:0]  p1_s2;
    egp_pad_s    pad0;
    egp_pad_s    pad1;
    logic [7:0]  p0_in;
    logic [7:0]  p1_in;
    logic [7:0]  irq0;
    logic [1:0]  irq1;
    logic        cmp_en;
  } egp_state_s;
endpackage

//--- rtl/egp_port.sv
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
`include "egp_cfg.svh"

module egp_port (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic        rmw_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // Standby and interrupt enables
  input  wire logic        stby_enter_i,
  input  wire logic [7:0]  irq0_en_i,
  input  wire logic [1:0]  irq1_en_i,
  // Peripheral outputs per port
  input  wire logic [7:0]  p0_per_oe_i,
  input  wire logic [7:0]  p0_per_out_i,
  input  wire logic [7:0]  p1_per_oe_i,
  input  wire logic [7:0]  p1_per_out_i,
  input  wire logic [7:0]  p1_open_drain_i,
  // Pads
  input  wire logic [7:0]  p0_pin_i,
  input  wire logic [7:0]  p1_pin_i,
  output logic [7:0]       p0_pin_o,
  output logic [7:0]       p0_pin_oe_n_o,
  output logic [7:0]       p0_pull_o,
  output logic [7:0]       p1_pin_o,
  output logic [7:0]       p1_pin_oe_n_o,
  output logic [7:0]       p1_pull_o,
  // Inputs to peripherals
  output logic [7:0]       p0_in_o,
  output logic [7:0]       p1_in_o,
  output logic [7:0]       irq0_in_o,
  output logic [1:0]       irq1_in_o,
  output logic             cmp_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  egp_pkg::egp_state_s q;       // Registered state
  egp_pkg::egp_state_s d;       // Next state
  logic                isolate; // Pins floated by standby
  logic                hit;     // New bus request
  logic [7:0]          wb0;     // Byte lane 0 write data

  // A request is taken only while the slave is idle, so one
  // still held in the ack cycle is never taken twice
  assign hit = cyc_i && stb_i && (q.phase == egp_pkg::EGP_IDLE);
  assign wb0 = dat_i[7:0];
  // Standby entry and the isolate bit are both needed; either
  // one alone leaves the pads as they were
  // Isolation condition
  assign isolate = q.stby[`EGP_STBY_ISO_BIT] && q.stby[`EGP_STBY_MODE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive, one generate entry per pin
  egp_pkg::egp_pad_s pd0;       // Port 0 next pad drive
  egp_pkg::egp_pad_s pd1;       // Port 1 next pad drive
  logic [7:0]        gin0;      // Port 0 gated input
  logic [7:0]        gin1;      // Port 1 gated input
  logic [7:0]        open0;     // Port 0 input kept open
  logic [7:0]        open1;     // Port 1 input kept open

  // Peripheral enable outranks the direction bit, so a pin can
  // be handed to a peripheral without touching the port setup
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      logic hi0;
      logic hi1;
      logic drv0;
      logic drv1;
      // Peripheral output takes priority over latch
      assign drv0 = p0_per_oe_i[gi] | q.p0_dir[gi];
      assign drv1 = p1_per_oe_i[gi] | q.p1_dir[gi];
      assign hi0 = p0_per_oe_i[gi] ? p0_per_out_i[gi] : q.p0_data[gi];
      assign hi1 = p1_per_oe_i[gi] ? p1_per_out_i[gi] : q.p1_data[gi];
      // Direction zero leaves pin undriven unless the peripheral enable is set
      // Port 0 has no open-drain pins, only port 1 does
      assign pd0.out[gi]  = hi0;
      assign pd0.oe_n[gi] = isolate | ~drv0;
      assign pd1.out[gi]  = hi1 & ~p1_open_drain_i[gi];
      assign pd1.oe_n[gi] = isolate | ~drv1
                          | (p1_open_drain_i[gi] & hi1);
      // Pull-up when set, never on port 1 pin 2; dropped when driving low
      assign pd0.pull[gi] = q.p0_pull[gi] & ~(~pd0.oe_n[gi] & ~hi0);
      if (gi == `EGP_P1_NOPULL_BIT) begin : g_nopull
        assign pd1.pull[gi] = 1'b0;
      end else begin : g_pull
        assign pd1.pull[gi] = q.p1_pull[gi]
                            & ~(~pd1.oe_n[gi] & ~pd1.out[gi]);
      end
      assign open0[gi] = ~isolate | irq0_en_i[gi];
      // Blocked input reads low; analog disable
      assign gin0[gi]  = q.p0_s2[gi] & open0[gi] & q.ain_dis[gi];
      if (gi == `EGP_P1_SCK_BIT) begin : g_sck
        assign open1[gi] = ~isolate | irq1_en_i[0];
      end else if (gi == `EGP_P1_SRX_BIT) begin : g_srx
        assign open1[gi] = ~isolate | irq1_en_i[1];
      end else begin : g_plain
        assign open1[gi] = ~isolate;
      end
      assign gin1[gi] = q.p1_s2[gi] & open1[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  // Read data is picked from the request's address in the take
  // cycle and shown together with the ack one cycle later
  logic [7:0] rd_byte; // Selected read byte

  always_comb begin
    rd_byte = 8'h00;
    case (adr_i)
      // Output reads latch; input reads pin
      `EGP_OFS_P0_DATA:
        rd_byte = rmw_i ? q.p0_data
                : ((q.p0_dir & ~p0_per_oe_i & q.p0_data)
                 | (~(q.p0_dir & ~p0_per_oe_i) & gin0));
      `EGP_OFS_P0_DIR:  rd_byte = q.p0_dir;
      `EGP_OFS_P0_PULL: rd_byte = q.p0_pull;
      `EGP_OFS_AIN_DIS: rd_byte = q.ain_dis;
      `EGP_OFS_P1_DATA:
        rd_byte = rmw_i ? q.p1_data
                : ((q.p1_dir & ~p1_per_oe_i & q.p1_data)
                 | (~(q.p1_dir & ~p1_per_oe_i) & gin1));
      `EGP_OFS_P1_DIR:  rd_byte = q.p1_dir;
      `EGP_OFS_P1_PULL: rd_byte = q.p1_pull;
      `EGP_OFS_STBY:    rd_byte = {6'h00, q.stby};
      `EGP_OFS_CMP:     rd_byte = {7'h00, q.cmp_dis};
      default:          rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    // The first flop may go metastable, so nothing but the
    // second flop ever reads it
    // Two-flop synchronisers on pads
    d.p0_s1 = p0_pin_i;
    d.p0_s2 = q.p0_s1;
    d.p1_s1 = p1_pin_i;
    d.p1_s2 = q.p1_s1;
    // Mode follows the standby entry level
    d.stby[`EGP_STBY_MODE_BIT] = stby_enter_i;
    // Without isolation pads keep their drive
    d.pad0  = pd0;
    d.pad1  = pd1;
    d.p0_in = gin0;
    d.p1_in = gin1;
    // Interrupt pins feed the interrupt circuit
    d.irq0  = gin0 | (q.p0_s2 & open0);
    d.irq1  = {gin1[`EGP_P1_SRX_BIT], gin1[`EGP_P1_SCK_BIT]};
    d.cmp_en = ~q.cmp_dis;
    // Spending the ack cycle idle costs one cycle per access but
    // keeps a held request from being taken again
    // Bus slave: one-cycle ack, then idle
    if (q.phase == egp_pkg::EGP_ACK) begin
      d.phase = egp_pkg::EGP_IDLE;
    end else if (hit) begin
      d.phase = egp_pkg::EGP_ACK;
      d.rdat  = {24'h000000, rd_byte};
      if (we_i && sel_i[0]) begin
        case (adr_i)
          `EGP_OFS_P0_DATA: d.p0_data = wb0;
          `EGP_OFS_P0_DIR:  d.p0_dir  = wb0;
          `EGP_OFS_P0_PULL: d.p0_pull = wb0;
          `EGP_OFS_AIN_DIS: d.ain_dis = wb0;
          `EGP_OFS_P1_DATA: d.p1_data = wb0;
          `EGP_OFS_P1_DIR:  d.p1_dir  = wb0;
          `EGP_OFS_P1_PULL: d.p1_pull = wb0;
          `EGP_OFS_STBY:    d.stby[`EGP_STBY_ISO_BIT] = wb0[0];
          `EGP_OFS_CMP:     d.cmp_dis = wb0[`EGP_CMP_DIS_BIT];
          default:          d.rdat = 32'h00000000;
        endcase
      end
    end
    // Reset wins over any bus write in the same cycle
    if (rst_i) begin
      d = '0;
      d.p0_dir  = `EGP_RST_BYTE;
      d.p1_dir  = `EGP_RST_BYTE;
      d.ain_dis = `EGP_RST_BYTE;
      d.cmp_dis = `EGP_RST_CMP;
      d.pad0.oe_n = 8'hff;
      d.pad1.oe_n = 8'hff;
    end
  end

  // One register for the whole state keeps reset and update
  // in a single place
  // Register the whole state
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad controls lag the registers by one cycle; the pads stay
  // glitch-free at the cost of that latency
  // Outputs straight from flops
  assign ack_o         = (q.phase == egp_pkg::EGP_ACK);
  assign dat_o         = q.rdat;
  assign p0_pin_o      = q.pad0.out;
  assign p0_pin_oe_n_o = q.pad0.oe_n;
  assign p0_pull_o     = q.pad0.pull;
  assign p1_pin_o      = q.pad1.out;
  assign p1_pin_oe_n_o = q.pad1.oe_n;
  assign p1_pull_o     = q.pad1.pull;
  assign p0_in_o       = q.p0_in;
  assign p1_in_o       = q.p1_in;
  assign irq0_in_o     = q.irq0;
  assign irq1_in_o     = q.irq1;
  assign cmp_en_o      = q.cmp_en;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Checks other than a_pull_low_off, a_nopull_bit and a_cmp_enable
  // look one cycle after their cause, because every output comes from a flop
  a_reset_dir_clear: assert property (
    @(posedge clk_i) rst_i |=> (q.p0_dir == 8'h00) && (q.p1_dir == 8'h00))
    else $error("direction not cleared by reset");
  a_reset_ain_clear: assert property (
    @(posedge clk_i) rst_i |=> (q.ain_dis == 8'h00))
    else $error("analog disable not cleared by reset");
  a_isolate_float: assert property (
    @(posedge clk_i) disable iff (rst_i)
    isolate |=> (p0_pin_oe_n_o == 8'hff) && (p1_pin_oe_n_o == 8'hff))
    else $error("pins driven during isolation");
  a_isolate_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (isolate && irq1_en_i == 2'b00) |=> (p1_in_o == 8'h00))
    else $error("isolated input not low");
  a_drive_latch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!isolate && q.p0_dir[1] && !p0_per_oe_i[1])
      |=> !p0_pin_oe_n_o[1] && (p0_pin_o[1] == $past(q.p0_data[1])))
    else $error("output pin not driving latch");
  a_input_float: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!q.p0_dir[3] && !p0_per_oe_i[3]) |=> p0_pin_oe_n_o[3])
    else $error("input pin driven");
  a_pull_low_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!p0_pin_oe_n_o[0] && !p0_pin_o[0]) |-> !p0_pull_o[0])
    else $error("pull-up on while driving low");
  a_nopull_bit: assert property (
    @(posedge clk_i) disable iff (rst_i) !p1_pull_o[2])
    else $error("pull-up on pin without pull-up");
  a_cmp_enable: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !q.cmp_dis ##1 !q.cmp_dis |-> cmp_en_o)
    else $error("comparator input not enabled");
  a_ack_once: assert property (
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

  // Isolated pins with no interrupt enable must read low
  a_iso_p0_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (isolate && (irq0_en_i == 8'h00))
      |=> (p0_in_o == 8'h00) && (irq0_in_o == 8'h00))
    else $error("blocked port 0 input not low");

  // An enabled interrupt channel still sees its pin
  a_irq_keep_open: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (isolate && irq0_en_i[2]) |=> (irq0_in_o[2] == $past(q.p0_s2[2])))
    else $error("enabled interrupt input blocked");

  // Serial clock pin stays open when its interrupt is on
  a_serial_open: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (isolate && irq1_en_i[0]) |=> (p1_in_o[4] == $past(q.p1_s2[4])))
    else $error("serial clock input blocked");

  // Standby without isolation leaves an output driving
  a_standby_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q.stby[`EGP_STBY_MODE_BIT] && !q.stby[`EGP_STBY_ISO_BIT]
     && q.p1_dir[1] && !p1_per_oe_i[1] && !p1_open_drain_i[1])
      |=> !p1_pin_oe_n_o[1] && (p1_pin_o[1] == $past(q.p1_data[1])))
    else $error("output dropped in standby");

  // Interrupt circuit follows the pin outside isolation
  a_irq_route: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !isolate |=> (irq0_in_o == $past(q.p0_s2)))
    else $error("pin not routed to interrupt circuit");

  // Pull-up bit on an undriven pin connects the pull-up
  a_pull_connect: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q.p0_pull[2] && !q.p0_dir[2] && !p0_per_oe_i[2]) |=> p0_pull_o[2])
    else $error("pull-up not connected");

  // Disable bit set closes the comparator path
  a_cmp_disable: assert property (
    @(posedge clk_i) disable iff (rst_i) q.cmp_dis |=> !cmp_en_o)
    else $error("comparator input not disabled");

  // A taken data write with byte lane 0 selected always lands in the latch
  a_latch_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (hit && we_i && sel_i[0] && (adr_i == `EGP_OFS_P1_DATA))
      |=> (q.p1_data == $past(dat_i[7:0])))
    else $error("data write missed the latch");

  // A modify-read of the data register returns the latch
  a_read_latch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (hit && !we_i && rmw_i && (adr_i == `EGP_OFS_P1_DATA))
      |=> (dat_o[7:0] == $past(q.p1_data)))
    else $error("modify-read did not return latch");

  // Peripheral output enable takes the pin
  a_periph_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!isolate && p1_per_oe_i[7] && !p1_open_drain_i[7])
      |=> !p1_pin_oe_n_o[7] && (p1_pin_o[7] == $past(p1_per_out_i[7])))
    else $error("peripheral output not on pin");

  // Open-drain output floats on one and pulls low on zero
  a_open_drain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!isolate && q.p1_dir[0] && !p1_per_oe_i[0] && p1_open_drain_i[0])
      |=> !p1_pin_o[0] && (p1_pin_oe_n_o[0] == $past(q.p1_data[0])))
    else $error("open-drain pin misdriven");

  // Analog disable set lets the pin through outside isolation
  a_digital_in: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q.ain_dis[3] && !isolate) |=> (p0_in_o[3] == $past(q.p0_s2[3])))
    else $error("digital input path not enabled");

endmodule

//--- bench/egp_pad_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// Far side of the pads: outside drivers, pull-ups, floats
module egp_pad_model (
  // Clock
  input  wire logic       clk_i,
  // Chip pad drive
  input  wire logic [7:0] dut_out_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] pull_i,
  // Outside driver
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  // Resolved level
  output logic      [7:0] pin_lvl_o
);
  // Floating lines wander so a float never looks stable
  logic [7:0] wander_q = 8'h00;
  always_ff @(posedge clk_i) begin
    wander_q <= ~wander_q;
  end
  // Chip drive wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) pin_lvl_o[i] = dut_out_i[i];
      else if (ext_en_i[i]) pin_lvl_o[i] = ext_val_i[i];
      else if (pull_i[i]) pin_lvl_o[i] = 1'b1;
      else pin_lvl_o[i] = wander_q[i];
    end
  end
endmodule

//--- bench/tb_top.sv
`timescale 1ns/10ps
`include "egp_cfg.svh"
`define CK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  // Bench drive
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, rmw = 1'b0, stby = 1'b0;
  logic [7:0]  adr = 8'h00, p1oe = 8'h00, p1po = 8'h00;
  logic [7:0]  ie0 = 8'h00, e0 = 8'h3c, e1 = 8'h3c, x1 = 8'hff;
  logic [1:0]  ie1 = 2'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, dat;
  // Design outputs
  logic        ack, cmpen;
  logic [7:0]  p0o, p0n, p0u, p1o, p1n, p1u, p0l, p1l, p0in, p1in, irq0;
  logic [1:0]  irq1;
  int          num_errors = 0, n_checks = 0, cyc_cnt = 0;

  initial forever #5 clk_i = ~clk_i;

  egp_port DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .rmw_i(rmw),
    .ack_o(ack), .dat_o(dat), .stby_enter_i(stby), .irq0_en_i(ie0),
    .irq1_en_i(ie1), .p0_per_oe_i(8'h00), .p0_per_out_i(8'h00),
    .p1_per_oe_i(p1oe), .p1_per_out_i(p1po), .p1_open_drain_i(8'h01),
    .p0_pin_i(p0l), .p1_pin_i(p1l), .p0_pin_o(p0o), .p0_pin_oe_n_o(p0n),
    .p0_pull_o(p0u), .p1_pin_o(p1o), .p1_pin_oe_n_o(p1n), .p1_pull_o(p1u),
    .p0_in_o(p0in), .p1_in_o(p1in), .irq0_in_o(irq0), .irq1_in_o(irq1),
    .cmp_en_o(cmpen));
  egp_pad_model pad0 (.clk_i(clk_i), .dut_out_i(p0o), .oe_n_i(p0n),
    .pull_i(p0u), .ext_en_i(8'hff), .ext_val_i(e0), .pin_lvl_o(p0l));
  egp_pad_model pad1 (.clk_i(clk_i), .dut_out_i(p1o), .oe_n_i(p1n),
    .pull_i(p1u), .ext_en_i(x1), .ext_val_i(e1), .pin_lvl_o(p1l));

  ////////////////////////////////////////////////////////////
  // Verdict, reached from the main flow or the watchdog
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One classic cycle; request held until ack is seen
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, input logic m);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a;
    wd <= {24'h0, d}; rmw <= m;
    sel <= 4'h1;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0; rmw <= 1'b0;
    sel <= 4'h0;
  endtask
  task automatic rdck(string nm, input logic [7:0] a, input logic m,
                      input logic [7:0] e);
    xfer(1'b0, a, 8'h00, m);
    `CK(nm, {24'h0, e}, rd)
  endtask
  // Pad lag plus two sync flops plus margin
  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask

  // Watchdog; whole run is under two hundred cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdck("p0_dir", `EGP_OFS_P0_DIR, 1'b0, 8'h00);
    rdck("p1_dir", `EGP_OFS_P1_DIR, 1'b0, 8'h00);
    rdck("ain_dis", `EGP_OFS_AIN_DIS, 1'b0, 8'h00);
    rdck("cmp", `EGP_OFS_CMP, 1'b0, 8'h01);
    `CK("p1_oe_n", 8'hff, p1n)
    `CK("p0_in_gated", 8'h00, p0in)
    `CK("irq0_in", 8'h3c, irq0)
    // Outputs; bit 0 is open drain
    xfer(1'b1, `EGP_OFS_P1_DATA, 8'ha5, 1'b0);
    xfer(1'b1, `EGP_OFS_P1_DIR, 8'hff, 1'b0);
    settle();
    `CK("p1_out", 8'ha4, p1o & 8'hfe)
    `CK("p1_oe_n_od", 8'h01, p1n)
    rdck("p1_rd_out", `EGP_OFS_P1_DATA, 1'b0, 8'ha5);
    xfer(1'b1, `EGP_OFS_P1_DATA, 8'ha4, 1'b0);
    settle();
    `CK("p1_od_low", 8'h00, p1n)
    // Mixed directions: high nibble reads the pin
    xfer(1'b1, `EGP_OFS_P1_DIR, 8'h0f, 1'b0);
    xfer(1'b1, `EGP_OFS_P1_DATA, 8'h5e, 1'b0);
    xfer(1'b1, `EGP_OFS_P1_PULL, 8'hff, 1'b0);
    settle();
    `CK("p1_oe_n_in", 8'hf0, p1n)
    `CK("p1_out_lo", 8'h0e, p1o & 8'h0f)
    rdck("p1_rd_pin", `EGP_OFS_P1_DATA, 1'b0, 8'h3e);
    rdck("p1_rd_rmw", `EGP_OFS_P1_DATA, 1'b1, 8'h5e);
    `CK("p1_pull", 8'hfa, p1u)
    rdck("p1_pull_rd", `EGP_OFS_P1_PULL, 1'b0, 8'hff);
    // Outside driver lets go of bit 7; the pull-up holds it high
    x1 <= 8'h7f;
    settle();
    rdck("p1_rd_pull", `EGP_OFS_P1_DATA, 1'b0, 8'hbe);
    // Peripheral drives bit 7 high
    p1oe <= 8'h80;
    p1po <= 8'h80;
    settle();
    `CK("p1_per_oe_n", 8'h70, p1n)
    rdck("p1_rd_per", `EGP_OFS_P1_DATA, 1'b0, 8'hbe);
    p1oe <= 8'h00;
    // Digital input on analog-capable pins
    xfer(1'b1, `EGP_OFS_AIN_DIS, 8'hff, 1'b0);
    settle();
    `CK("p0_in_open", 8'h3c, p0in)
    // Isolation with some interrupt inputs kept open
    ie0 <= 8'h0f;
    ie1 <= 2'h3;
    xfer(1'b1, `EGP_OFS_STBY, 8'h01, 1'b0);
    stby <= 1'b1;
    settle();
    `CK("p0_iso", 8'hff, p0n)
    `CK("p1_iso", 8'hff, p1n)
    `CK("p0_in_iso", 8'h0c, p0in)
    `CK("p1_in_iso", 8'h10, p1in)
    // Disabled channels are blocked from the interrupt circuit too
    `CK("irq0_iso", 8'h0c, irq0)
    ie0 <= 8'h00;
    ie1 <= 2'h0;
    settle();
    `CK("p1_in_block", 8'h00, p1in)
    `CK("p0_in_block", 8'h00, p0in)
    xfer(1'b1, `EGP_OFS_STBY, 8'h00, 1'b0);
    settle();
    `CK("p1_keep", 8'hf0, p1n)
    stby <= 1'b0;
    // Comparator pins: pull-ups off and analog disable cleared first
    xfer(1'b1, `EGP_OFS_P0_PULL, 8'h00, 1'b0);
    xfer(1'b1, `EGP_OFS_AIN_DIS, 8'hfc, 1'b0);
    // Comparator path both ways
    xfer(1'b1, `EGP_OFS_CMP, 8'h00, 1'b0);
    settle();
    `CK("cmp_on", 1'b1, cmpen)
    xfer(1'b1, `EGP_OFS_CMP, 8'h01, 1'b0);
    settle();
    `CK("cmp_off", 1'b0, cmpen)
    // Port 0 outputs: bit 0 low with pull-up set, bit 2 input pulled
    xfer(1'b1, `EGP_OFS_P0_DATA, 8'h02, 1'b0);
    xfer(1'b1, `EGP_OFS_P0_PULL, 8'h05, 1'b0);
    xfer(1'b1, `EGP_OFS_P0_DIR, 8'h03, 1'b0);
    settle();
    `CK("p0_oe_n", 8'hfc, p0n)
    `CK("p0_out", 8'h02, p0o & 8'h03)
    `CK("p0_pull", 8'h04, p0u)
    rdck("p0_rd_out", `EGP_OFS_P0_DATA, 1'b0, 8'h3e);
    rdck("unmapped", 8'h24, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule
